// ### pkg/snc_pkg.sv
// Purpose: Shared constants and carrier types for the switch node configuration bank.
// Assumes: One 8-bit register number per 32-bit register, on the core clock.
// Notes:   Identity values are parameters of the top module, not constants here.
package snc_pkg;

  localparam logic [7:0] SNC_REG_IDENT   = 8'h00;
  localparam logic [7:0] SNC_REG_TOPO    = 8'h01;
  localparam logic [7:0] SNC_REG_LOCK    = 8'h04;
  localparam logic [7:0] SNC_REG_NODE_ID = 8'h05;
  localparam logic [7:0] SNC_REG_PLL     = 8'h06;
  localparam logic [7:0] SNC_REG_SW_DIV  = 8'h07;
  localparam logic [7:0] SNC_REG_REF_DIV = 8'h08;
  localparam logic [7:0] SNC_REG_SCAN_ID = 8'h09;
  localparam logic [7:0] SNC_REG_USER    = 8'h0a;
  localparam logic [7:0] SNC_REG_DIR_LO  = 8'h0c;
  localparam logic [7:0] SNC_REG_DIR_HI  = 8'h0d;

  localparam int SNC_LOCK_ALL_BIT = 31;
  localparam int SNC_LOCK_PLL_BIT = 8;
  localparam int SNC_HDR_BIT      = 0;

  localparam int SNC_PLL_NORST_BIT  = 31;
  localparam int SNC_PLL_NOWAIT_BIT = 30;
  localparam int SNC_PLL_BYPASS_BIT = 29;
  localparam int SNC_PLL_JTAG_BIT   = 28;
  localparam int SNC_PLL_OD_LSB     = 23;
  localparam int SNC_PLL_F_LSB      = 8;
  localparam int SNC_PLL_R_LSB      = 0;

  localparam logic [31:0] SNC_PLL_WR_MASK  = 32'hf39f_ff7f;
  localparam logic [31:0] SNC_PLL_RST_VAL  = 32'h0000_0000;
  localparam logic [15:0] SNC_NODE_ID_RST  = 16'h0000;
  localparam logic [15:0] SNC_SW_DIV_RST   = 16'h0000;
  localparam logic [15:0] SNC_REF_DIV_RST  = 16'h0003;
  localparam logic [3:0]  SNC_DIR_RST      = 4'h0;

  localparam int SNC_NUM_DIMS = 16;
  localparam int SNC_DIRS_PER_REG = 8;
  localparam int SNC_DIR_W = 4;

  typedef struct packed {
    logic        wr;
    logic [7:0]  addr;
    logic [31:0] wdata;
  } snc_cfg_req_t;

  typedef struct packed {
    logic        ack;
    logic        err;
    logic [31:0] rdata;
  } snc_cfg_rsp_t;

  typedef struct packed {
    logic       valid;
    logic       local_hit;
    logic [3:0] dim;
    logic [3:0] dir;
  } snc_route_t;

endpackage

// ### rtl/snc_route_lookup.sv
// Purpose: Finds the most significant bit where a destination differs from this node.
// Assumes: Both identifiers are 16 bits; purely combinational.
// Notes:   No mismatch means the packet is for this node.
`timescale 1ns/1ps
module snc_route_lookup
  import snc_pkg::*;
(
  input  wire logic [15:0] dest_id_i,
  input  wire logic [15:0] node_id_i,
  output logic             mismatch_o,
  output logic [3:0]       dim_o
);

  logic [15:0] diff;

  assign diff = dest_id_i ^ node_id_i; // R21

  // The loop climbs upward so the highest differing bit is the last to win.
  always_comb begin
    mismatch_o = 1'b0;
    dim_o      = 4'h0;
    for (int i = 0; i < SNC_NUM_DIMS; i++) begin
      if (diff[i]) begin
        mismatch_o = 1'b1;
        dim_o      = 4'(i); // R20
      end
    end
  end

endmodule

// ### rtl/snc_config.sv
// Purpose: Configuration register bank and routing table of the switch node.
// Assumes: Config requests come from logic on core_clk_i; boot pins are asynchronous.
// Notes:   Each request is answered one cycle later; requests may follow back to back.
// Notes on behaviour
// R1 - Identity register reads boot pins at reset, revision and version.
// R2 - Topology register reads link count, attached and device processor counts.
// R3 - Lock bit 31 set refuses all writes to switch control registers.
// R4 - Lock bit 8 set blocks writes to the PLL setup register.
// R5 - Bit 0 picks header length: zero two bytes, one a single byte.
// R6 - Sixteen-bit writable node identifier, zero after reset.
// R7 - Any accepted PLL setup write resets the tile unless suppressed.
// R8 - PLL write with bit 31 set applies settings without chip reset.
// R9 - PLL write bit 30 skips waiting for re-lock; software uses it sparingly.
// R10 - PLL bit 29 bypasses the PLL with the input clock.
// R11 - PLL bit 28 forces boot through the scan port.
// R12 - Output divider sits in PLL bits 25:23, values zero to seven.
// R13 - Feedback ratio sits in PLL bits 20:8.
// R14 - Input divider sits in PLL bits 6:0.
// R15 - Switch clock ratio field bits 15:0, reset zero.
// R16 - Reference clock divider bits 15:0, reset three.
// R17 - User code register reads programmed code and metal fix code.
// R18 - Low table holds directions for dimensions zero to seven.
// R19 - High table holds directions for dimensions eight to fifteen.
// R20 - Route by direction of the highest bit differing from node id.
// R21 - Mismatch found by exclusive-or; refused writes are silently dropped.
`timescale 1ns/1ps
module snc_config
  import snc_pkg::*;
#(
  parameter logic [7:0]  SW_VERSION   = 8'h11, // Arbitrary value.
  parameter logic [7:0]  SW_REVISION  = 8'h22, // Arbitrary value.
  parameter logic [7:0]  NUM_LINKS    = 8'h08,
  parameter logic [7:0]  NUM_PROC_SW  = 8'h02,
  parameter logic [7:0]  NUM_PROC_DEV = 8'h02,
  parameter logic [31:0] SCAN_ID      = 32'h1234_5677, // Arbitrary value.
  parameter logic [17:0] METAL_ID     = 18'h0_0a5a  // Arbitrary value.
) (
  input  wire logic         core_clk_i,
  input  wire logic         rst_b_i,
  input  wire logic         cfg_valid_i,
  input  wire snc_cfg_req_t cfg_req_i,
  output snc_cfg_rsp_t      cfg_rsp_o,
  input  wire logic [7:0]   boot_select_pins_i,
  input  wire logic [13:0]  otp_user_code_i,
  input  wire logic         route_req_i,
  input  wire logic [15:0]  route_dest_i,
  output snc_route_t        route_o,
  output logic              hdr_one_byte_o,
  output logic [15:0]       node_id_o,
  output logic [2:0]        pll_output_divider_o,
  output logic [12:0]       pll_feedback_o,
  output logic [6:0]        pll_input_div_o,
  output logic              pll_bypass_o,
  output logic              pll_jtag_boot_o,
  output logic              pll_skip_relock_o,
  output logic              pll_update_o,
  output logic              tile_rst_o,
  output logic [15:0]       sw_clk_ratio_o,
  output logic [15:0]       ref_div_o
);

  logic [7:0]   boot_meta_ff;
  logic [7:0]   boot_sync_ff;
  logic [7:0]   boot_cap_ff;
  logic [1:0]   boot_wait_ff;
  logic         boot_done_ff;
  logic         lock_all_ff;
  logic         lock_pll_ff;
  logic         hdr_ff;
  logic [15:0]  node_id_ff;
  logic [31:0]  pll_ff;
  logic [15:0]  sw_div_ff;
  logic [15:0]  ref_div_ff;
  logic [3:0]   dir_ff [SNC_NUM_DIMS];
  logic         tile_rst_ff;
  logic         pll_upd_ff;
  snc_cfg_rsp_t rsp_ff;
  snc_cfg_rsp_t nxt_rsp;
  snc_route_t   route_ff;
  logic         wr_ok;
  logic         pll_wr_ok;
  logic         hit;
  logic [3:0]   dim;

  // A locked bank stays locked until reset; otherwise the lock would protect nothing.
  assign wr_ok     = cfg_valid_i && cfg_req_i.wr && !lock_all_ff; // R3 R21
  assign pll_wr_ok = wr_ok && (cfg_req_i.addr == SNC_REG_PLL) && !lock_pll_ff; // R4

  // Boot pins are strapped: synchronised first, then caught once after release.
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      boot_meta_ff <= 8'h00;
      boot_sync_ff <= 8'h00;
    end else begin
      boot_meta_ff <= boot_select_pins_i;
      boot_sync_ff <= boot_meta_ff;
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      boot_cap_ff  <= 8'h00;
      boot_wait_ff <= 2'h0;
      boot_done_ff <= 1'b0;
    end else if (!boot_done_ff) begin
      // The synchroniser needs two edges to fill, so the capture waits for the third.
      boot_wait_ff <= {boot_wait_ff[0], 1'b1};
      if (boot_wait_ff[1]) begin
        boot_cap_ff  <= boot_sync_ff; // R1
        boot_done_ff <= 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      lock_all_ff <= 1'b0;
      lock_pll_ff <= 1'b0;
      hdr_ff      <= 1'b0;
    end else if (wr_ok && cfg_req_i.addr == SNC_REG_LOCK) begin
      lock_all_ff <= cfg_req_i.wdata[SNC_LOCK_ALL_BIT]; // R3
      lock_pll_ff <= cfg_req_i.wdata[SNC_LOCK_PLL_BIT]; // R4
      hdr_ff      <= cfg_req_i.wdata[SNC_HDR_BIT]; // R5
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      node_id_ff <= SNC_NODE_ID_RST;
    end else if (wr_ok && cfg_req_i.addr == SNC_REG_NODE_ID) begin
      node_id_ff <= cfg_req_i.wdata[15:0]; // R6
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      pll_ff <= SNC_PLL_RST_VAL;
    end else if (pll_wr_ok) begin
      pll_ff <= cfg_req_i.wdata & SNC_PLL_WR_MASK; // R12 R13 R14
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      tile_rst_ff <= 1'b0;
      pll_upd_ff  <= 1'b0;
    end else begin
      tile_rst_ff <= pll_wr_ok && !cfg_req_i.wdata[SNC_PLL_NORST_BIT]; // R7 R8
      pll_upd_ff  <= pll_wr_ok;
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      sw_div_ff  <= SNC_SW_DIV_RST;
      ref_div_ff <= SNC_REF_DIV_RST;
    end else begin
      if (wr_ok && cfg_req_i.addr == SNC_REG_SW_DIV) begin
        sw_div_ff <= cfg_req_i.wdata[15:0]; // R15
      end
      if (wr_ok && cfg_req_i.addr == SNC_REG_REF_DIV) begin
        ref_div_ff <= cfg_req_i.wdata[15:0]; // R16
      end
    end
  end

  for (genvar gi = 0; gi < SNC_NUM_DIMS; gi++) begin : g_dir
    localparam logic [7:0] DIR_ADDR = (gi < SNC_DIRS_PER_REG) ? SNC_REG_DIR_LO : SNC_REG_DIR_HI;
    localparam int         NIB_LSB  = (gi % SNC_DIRS_PER_REG) * SNC_DIR_W;
    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
        dir_ff[gi] <= SNC_DIR_RST;
      end else if (wr_ok && cfg_req_i.addr == DIR_ADDR) begin
        dir_ff[gi] <= cfg_req_i.wdata[NIB_LSB +: SNC_DIR_W]; // R18 R19
      end
    end
  end

  // Reserved bits read as zero; unknown numbers answer with the error flag.
  always_comb begin
    nxt_rsp       = '0;
    nxt_rsp.ack   = cfg_valid_i;
    unique case (cfg_req_i.addr)
      SNC_REG_IDENT:   nxt_rsp.rdata = {8'h00, boot_cap_ff, SW_REVISION, SW_VERSION}; // R1
      SNC_REG_TOPO:    nxt_rsp.rdata = {8'h00, NUM_LINKS, NUM_PROC_SW, NUM_PROC_DEV}; // R2
      SNC_REG_LOCK:    nxt_rsp.rdata = {lock_all_ff, 22'h0, lock_pll_ff, 7'h0, hdr_ff};
      SNC_REG_NODE_ID: nxt_rsp.rdata = {16'h0000, node_id_ff};
      SNC_REG_PLL:     nxt_rsp.rdata = pll_ff;
      SNC_REG_SW_DIV:  nxt_rsp.rdata = {16'h0000, sw_div_ff};
      SNC_REG_REF_DIV: nxt_rsp.rdata = {16'h0000, ref_div_ff};
      SNC_REG_SCAN_ID: nxt_rsp.rdata = SCAN_ID;
      SNC_REG_USER:    nxt_rsp.rdata = {otp_user_code_i, METAL_ID}; // R17
      SNC_REG_DIR_LO:  nxt_rsp.rdata = {dir_ff[7], dir_ff[6], dir_ff[5], dir_ff[4],
                                        dir_ff[3], dir_ff[2], dir_ff[1], dir_ff[0]};
      SNC_REG_DIR_HI:  nxt_rsp.rdata = {dir_ff[15], dir_ff[14], dir_ff[13], dir_ff[12],
                                        dir_ff[11], dir_ff[10], dir_ff[9], dir_ff[8]};
      default:         nxt_rsp.err   = cfg_valid_i;
    endcase
    if (!cfg_valid_i || cfg_req_i.wr) begin
      nxt_rsp.rdata = 32'h0000_0000;
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rsp_ff <= '0;
    end else begin
      rsp_ff <= nxt_rsp;
    end
  end

  snc_route_lookup u_lookup (
    .dest_id_i  (route_dest_i),
    .node_id_i  (node_id_ff),
    .mismatch_o (hit),
    .dim_o      (dim)
  );

  // A packet for this node gets no direction; the switch hands it to a local processor.
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      route_ff <= '0;
    end else begin
      route_ff.valid     <= route_req_i;
      route_ff.local_hit <= route_req_i && !hit;
      route_ff.dim       <= dim;
      route_ff.dir       <= hit ? dir_ff[dim] : SNC_DIR_RST; // R20 R21
    end
  end

  assign cfg_rsp_o            = rsp_ff;
  assign route_o              = route_ff;
  assign hdr_one_byte_o       = hdr_ff;
  assign node_id_o            = node_id_ff;
  assign pll_output_divider_o = pll_ff[SNC_PLL_OD_LSB +: 3]; // R12
  assign pll_feedback_o       = pll_ff[SNC_PLL_F_LSB +: 13]; // R13
  assign pll_input_div_o      = pll_ff[SNC_PLL_R_LSB +: 7]; // R14
  assign pll_bypass_o         = pll_ff[SNC_PLL_BYPASS_BIT]; // R10
  assign pll_jtag_boot_o      = pll_ff[SNC_PLL_JTAG_BIT]; // R11
  assign pll_skip_relock_o    = pll_ff[SNC_PLL_NOWAIT_BIT]; // R9
  assign pll_update_o         = pll_upd_ff;
  assign tile_rst_o           = tile_rst_ff;
  assign sw_clk_ratio_o       = sw_div_ff;
  assign ref_div_o            = ref_div_ff;

  // Checks.
  sequence s_pll_write;
    cfg_valid_i && cfg_req_i.wr && cfg_req_i.addr == SNC_REG_PLL;
  endsequence

  sequence s_tile_pulse;
    tile_rst_o ##1 (!tile_rst_o || $past(cfg_valid_i));
  endsequence

  a_lock_all_hold: assert property (@(posedge core_clk_i) disable iff (!rst_b_i) // R3
    lock_all_ff && cfg_valid_i && cfg_req_i.wr |=> $stable(node_id_o) && $stable(ref_div_o)
      && lock_all_ff)
    else $error("write taken while bank locked");

  a_lock_pll_hold: assert property (@(posedge core_clk_i) disable iff (!rst_b_i) // R4
    s_pll_write ##0 lock_pll_ff |=> $stable(pll_ff) && !pll_update_o && !tile_rst_o)
    else $error("PLL write taken while PLL locked");

  a_tile_rst_pulse: assert property (@(posedge core_clk_i) disable iff (!rst_b_i) // R7
    s_pll_write ##0 (!lock_all_ff && !lock_pll_ff && !cfg_req_i.wdata[31]) |=> s_tile_pulse)
    else $error("tile reset pulse missing after PLL write");

  a_no_chip_rst: assert property (@(posedge core_clk_i) disable iff (!rst_b_i) // R8
    s_pll_write ##0 cfg_req_i.wdata[31] |=> !tile_rst_o)
    else $error("tile reset despite suppress bit");

  a_pll_fields_upd: assert property (@(posedge core_clk_i) disable iff (!rst_b_i) // R12
    s_pll_write ##0 (!lock_all_ff && !lock_pll_ff) |=> pll_update_o
      && pll_output_divider_o == $past(cfg_req_i.wdata[25:23])
      && pll_feedback_o == $past(cfg_req_i.wdata[20:8])
      && pll_skip_relock_o == $past(cfg_req_i.wdata[30])
      && pll_bypass_o == $past(cfg_req_i.wdata[29]))
    else $error("PLL fields not taken from write");

  a_hdr_mode_set: assert property (@(posedge core_clk_i) disable iff (!rst_b_i) // R5
    wr_ok && cfg_req_i.addr == SNC_REG_LOCK |=> hdr_one_byte_o == $past(cfg_req_i.wdata[0]))
    else $error("header mode not updated");

  a_ident_read: assert property (@(posedge core_clk_i) disable iff (!rst_b_i) // R1
    cfg_valid_i && !cfg_req_i.wr && cfg_req_i.addr == SNC_REG_IDENT
      |=> cfg_rsp_o.ack && cfg_rsp_o.rdata[23:16] == $past(boot_cap_ff)
      && cfg_rsp_o.rdata[31:24] == 8'h00)
    else $error("identity read wrong");

  a_route_answer: assert property (@(posedge core_clk_i) disable iff (!rst_b_i) // R20
    route_req_i && (route_dest_i[15] != node_id_o[15])
      && $stable(node_id_o) |=> route_o.valid && route_o.dim == 4'hf
      && route_o.dir == $past(dir_ff[15]))
    else $error("route for top dimension wrong");

  a_route_local: assert property (@(posedge core_clk_i) disable iff (!rst_b_i) // R21
    route_req_i && route_dest_i == node_id_o |=> route_o.local_hit && route_o.dir == 4'h0)
    else $error("local packet not flagged");

  a_ack_next: assert property (@(posedge core_clk_i) disable iff (!rst_b_i) // Each request is acknowledged one cycle later.
    cfg_valid_i |=> cfg_rsp_o.ack ##1 (cfg_rsp_o.ack == $past(cfg_valid_i)))
    else $error("request answer timing wrong");

endmodule

// ### sim/tb_top.sv
// Purpose: Self-checking bench for the switch node configuration bank.
// Assumes: One request at a time; answers are sampled one cycle after each request.
// Notes:   Identity values are handed to the design so that expectations follow from them.
`timescale 1ns/1ps
module tb_top
  import snc_pkg::*;
;
  localparam logic [7:0]  T_VER   = 8'h3c; // Arbitrary value.
  localparam logic [7:0]  T_REV   = 8'h4d; // Arbitrary value.
  localparam logic [7:0]  T_LINKS = 8'h06;
  localparam logic [7:0]  T_PSW   = 8'h03;
  localparam logic [7:0]  T_PDEV  = 8'h01;
  localparam logic [31:0] T_SCAN  = 32'h0bad_c0d1; // Arbitrary value.
  localparam logic [17:0] T_METAL = 18'h2_1357; // Arbitrary value.
  localparam logic [7:0]  T_BOOT  = 8'h5a;
  localparam logic [13:0] T_OTP   = 14'h1abc;
  localparam logic [15:0] T_NODE  = 16'habcd;

  logic         core_clk_i;
  logic         rst_b_i;
  logic         cfg_valid_i;
  snc_cfg_req_t cfg_req_i;
  snc_cfg_rsp_t cfg_rsp_o;
  logic         route_req_i;
  logic [15:0]  route_dest_i;
  snc_route_t   route_o;
  logic         hdr_one_byte_o;
  logic [15:0]  node_id_o;
  logic [2:0]   pll_output_divider_o;
  logic [12:0]  pll_feedback_o;
  logic [6:0]   pll_input_div_o;
  logic         pll_bypass_o;
  logic         pll_jtag_boot_o;
  logic         pll_skip_relock_o;
  logic         pll_update_o;
  logic         tile_rst_o;
  logic [15:0]  sw_clk_ratio_o;
  logic [15:0]  ref_div_o;
  logic [1:0]   pulse_s;
  logic [31:0]  q;
  int           failures;
  int           compares;
  int           cycles;

  snc_config #(.SW_VERSION(T_VER), .SW_REVISION(T_REV), .NUM_LINKS(T_LINKS),
    .NUM_PROC_SW(T_PSW), .NUM_PROC_DEV(T_PDEV), .SCAN_ID(T_SCAN), .METAL_ID(T_METAL)) dut (
    .core_clk_i(core_clk_i), .rst_b_i(rst_b_i), .cfg_valid_i(cfg_valid_i),
    .cfg_req_i(cfg_req_i), .cfg_rsp_o(cfg_rsp_o), .boot_select_pins_i(T_BOOT),
    .otp_user_code_i(T_OTP), .route_req_i(route_req_i), .route_dest_i(route_dest_i),
    .route_o(route_o), .hdr_one_byte_o(hdr_one_byte_o), .node_id_o(node_id_o),
    .pll_output_divider_o(pll_output_divider_o), .pll_feedback_o(pll_feedback_o),
    .pll_input_div_o(pll_input_div_o), .pll_bypass_o(pll_bypass_o),
    .pll_jtag_boot_o(pll_jtag_boot_o), .pll_skip_relock_o(pll_skip_relock_o),
    .pll_update_o(pll_update_o), .tile_rst_o(tile_rst_o),
    .sw_clk_ratio_o(sw_clk_ratio_o), .ref_div_o(ref_div_o));

  initial core_clk_i = 1'b0;
  always #50 core_clk_i = ~core_clk_i;

  task automatic end_of_test();
    if (failures == 0 && compares > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // The ceiling is far above the roughly 120 cycles the sequence needs.
  always @(posedge core_clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      failures = failures + 1;
      end_of_test();
    end
  end

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    compares = compares + 1;
    if (g !== e) begin
      failures = failures + 1;
      $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  // One request; the answer and the PLL pulses are taken at the next edge.
  task automatic cfg(input logic w, input logic [7:0] a, input logic [31:0] d,
                     input logic e, output logic [31:0] r);
    cfg_valid_i = 1'b1;
    cfg_req_i   = '{wr: w, addr: a, wdata: d};
    @(posedge core_clk_i);
    #1;
    chk({30'h0, cfg_rsp_o.ack, cfg_rsp_o.err}, {30'h0, 1'b1, e});
    r = cfg_rsp_o.rdata;
    pulse_s = {pll_update_o, tile_rst_o};
    cfg_valid_i = 1'b0;
    @(posedge core_clk_i);
    #1;
    chk({29'h0, cfg_rsp_o.ack, pll_update_o, tile_rst_o}, 32'h0);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    cfg(1'b1, a, d, 1'b0, q);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    cfg(1'b0, a, 32'h0, 1'b0, q);
    chk(q, e);
  endtask

  task automatic route(input logic [15:0] dst, input logic [9:0] e);
    route_req_i  = 1'b1;
    route_dest_i = dst;
    @(posedge core_clk_i);
    #1;
    chk({22'h0, route_o}, {22'h0, e});
    route_req_i = 1'b0;
    @(posedge core_clk_i);
    #1;
    chk({31'h0, route_o.valid}, 32'h0);
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge core_clk_i);
    #1;
  endtask

  initial begin
    failures = 0;
    compares = 0;
    cycles = 0;
    rst_b_i = 1'b0;
    cfg_valid_i = 1'b0;
    cfg_req_i = '0;
    route_req_i = 1'b0;
    route_dest_i = 16'h0;
    pulse_s = 2'h0;
    idle(4);
    rst_b_i = 1'b1;
    // Boot pins are captured a few edges after release, so identity is read later.
    rd(SNC_REG_LOCK, 32'h0);
    rd(SNC_REG_NODE_ID, 32'h0);
    rd(SNC_REG_SW_DIV, 32'h0);
    rd(SNC_REG_REF_DIV, 32'h3);
    rd(SNC_REG_DIR_LO, 32'h0);
    rd(SNC_REG_DIR_HI, 32'h0);
    idle(2);
    rd(SNC_REG_IDENT, {8'h0, T_BOOT, T_REV, T_VER});
    wr(SNC_REG_IDENT, 32'hffff_ffff);
    rd(SNC_REG_IDENT, {8'h0, T_BOOT, T_REV, T_VER});
    rd(SNC_REG_TOPO, {8'h0, T_LINKS, T_PSW, T_PDEV});
    rd(SNC_REG_SCAN_ID, T_SCAN);
    rd(SNC_REG_USER, {T_OTP, T_METAL});
    cfg(1'b0, 8'h02, 32'h0, 1'b1, q);
    chk(q, 32'h0);
    wr(SNC_REG_NODE_ID, {16'hffff, T_NODE});
    chk({16'h0, node_id_o}, {16'h0, T_NODE});
    rd(SNC_REG_NODE_ID, {16'h0, T_NODE});
    wr(SNC_REG_LOCK, 32'h0000_0001);
    chk({31'h0, hdr_one_byte_o}, 32'h1);
    rd(SNC_REG_LOCK, 32'h1);
    wr(SNC_REG_SW_DIV, 32'hffff_1234);
    wr(SNC_REG_REF_DIV, 32'h0000_beef);
    chk({sw_clk_ratio_o, ref_div_o}, 32'h1234_beef);
    rd(SNC_REG_SW_DIV, 32'h1234);
    rd(SNC_REG_REF_DIV, 32'hbeef);
    // A PLL write without the suppress bit resets the tile for one cycle.
    wr(SNC_REG_PLL, 32'h7fff_ffff);
    chk({30'h0, pulse_s}, 32'h3);
    chk({pll_bypass_o, pll_jtag_boot_o, pll_skip_relock_o}, 32'h7);
    chk({pll_output_divider_o, pll_feedback_o, pll_input_div_o}, 32'h7fff_ff);
    idle(1);
    chk({30'h0, pll_update_o, tile_rst_o}, 32'h0);
    rd(SNC_REG_PLL, 32'h739f_ff7f);
    wr(SNC_REG_PLL, 32'h8000_0102);
    chk({30'h0, pulse_s}, 32'h2);
    chk({pll_bypass_o, pll_jtag_boot_o, pll_skip_relock_o}, 32'h0);
    chk({pll_output_divider_o, pll_feedback_o, pll_input_div_o}, 32'h0082);
    // Routing: each table nibble holds its own dimension number.
    wr(SNC_REG_DIR_LO, 32'h7654_3210);
    wr(SNC_REG_DIR_HI, 32'hfedc_ba98);
    rd(SNC_REG_DIR_HI, 32'hfedc_ba98);
    for (int d = 0; d < 16; d++) begin
      route(T_NODE ^ (16'h1 << d) ^ ((16'h1 << d) - 16'h1), {1'b1, 1'b0, d[3:0], d[3:0]});
    end
    route(T_NODE, 10'h300);
    // Protection: PLL lock first, then the full lock.
    wr(SNC_REG_LOCK, 32'h0000_0100);
    wr(SNC_REG_PLL, 32'h0000_0005);
    chk({30'h0, pulse_s}, 32'h0);
    rd(SNC_REG_PLL, 32'h8000_0102);
    wr(SNC_REG_LOCK, 32'h8000_0101);
    wr(SNC_REG_NODE_ID, 32'h0000_1111);
    wr(SNC_REG_LOCK, 32'h0);
    rd(SNC_REG_NODE_ID, {16'h0, T_NODE});
    rd(SNC_REG_LOCK, 32'h8000_0101);
    chk({31'h0, hdr_one_byte_o}, 32'h1);
    // A second reset clears the lock and restores defaults.
    rst_b_i = 1'b0;
    idle(2);
    chk({node_id_o, ref_div_o}, 32'h0000_0003);
    rst_b_i = 1'b1;
    rd(SNC_REG_LOCK, 32'h0);
    wr(SNC_REG_NODE_ID, 32'h0000_0042);
    rd(SNC_REG_NODE_ID, 32'h0000_0042);
    end_of_test();
  end
endmodule
